/* src/fsl_lock.sv */
// Flash security lock: boot-time code fetch, command/read/debug gating, serial-boot setup
// Notes on behaviour
// - Halfword 0x0001 at code address arms lock
// - New code acts only after next reset
// - Chip erase, or in user mode a code or trim erase, plus reset unlocks
// - User mode locked: reads valid, all commands allowed except those from the debug port
// - Serial mode locked: only chip erase, reads invalid
// - Locked: debug port blocked in every mode
// - Debug port can never clear the lock
// - Code and trimming data always erased together
// - Mode pins 01 at reset enter serial-writer
// - Baud rate follows source oscillator frequency
// - Serial programming works on internal oscillator
module fsl_lock (
	input  wire logic                clock_i,        // 20 MHz system clock
	input  wire logic                rst_i,          // Asynchronous reset, active high
	input  wire logic [1:0]          boot_mode_pins_i, // Boot mode pins
	input  wire logic                serial_rx_select_pin_i, // Serial input pin level
	input  wire logic                main_clk_present_i, // Main oscillator running
	input  wire fsl_pkg::fsl_osc_t   osc_sel_i,      // Source oscillator frequency
	output logic                     fetch_req_o,    // Read request for the security code
	output logic [31:0]              fetch_addr_o,   // Address of that read
	input  wire logic                fetch_ack_i,    // Fetch data valid
	input  wire logic [15:0]         fetch_data_i,   // Fetched halfword
	input  wire fsl_pkg::fsl_cmd_t   cmd_i,          // Command request
	output logic                     cmd_accept_o,   // Command accepted pulse
	output logic                     cmd_reject_o,   // Command rejected pulse
	output fsl_pkg::fsl_erase_t      erase_o,        // Erase strobes to the array
	input  wire logic                rd_valid_i,     // Flash read data valid
	input  wire logic [31:0]         rd_data_i,      // Flash read data
	output logic                     rd_valid_o,     // Gated read data valid
	output logic [31:0]              rd_data_o,      // Gated read data
	output logic                     dbg_enable_o,   // Debug port may reach internals
	output fsl_pkg::fsl_status_t     status_o,       // Latched boot status
	output logic [15:0]              baud_bps_o      // Serial link baud rate
);
	import fsl_pkg::*;

	// Three-stage pin synchronisers; s1 feeds only s2
	logic [1:0]  mode_s1_reg;   // First stage, mode pins
	logic [1:0]  mode_s2_reg;   // Second stage
	logic [1:0]  mode_s3_reg;   // Third stage
	logic [1:0]  mode_reg;      // Accepted mode pin level
	// Second group: rx select and main clock present
	logic [1:0]  misc_s1_reg;   // First stage, rx select and clock present
	logic [1:0]  misc_s2_reg;   // Second stage
	logic [1:0]  misc_s3_reg;   // Third stage
	logic [1:0]  misc_reg;      // Accepted level, bit1 rx select, bit0 clock present

	// Boot sequencing and the per-reset lock flag
	fsl_state_t  state_reg;     // Boot sequence state
	fsl_state_t  state_next;    // Next boot state
	logic [2:0]  settle_reg;    // Settle counter
	logic        locked_reg;    // Lock flag for this reset period

	// Baud rate for a given oscillator
	function automatic logic [15:0] baud_of(input fsl_osc_t osc);
		unique case (osc)
			FSL_OSC_4M:  baud_of = BAUD_4M;
			FSL_OSC_8M:  baud_of = BAUD_8M;
			FSL_OSC_16M: baud_of = BAUD_16M;
			FSL_OSC_20M: baud_of = BAUD_20M;
			FSL_OSC_RC:  baud_of = BAUD_RC;
			// Unknown codes fall back to the internal oscillator rate
			default:     baud_of = BAUD_RC;
		endcase
	endfunction

	// Decide whether a command passes the lock
	function automatic logic cmd_allowed(input fsl_cmd_t c, input logic lk, input logic ser);
		// Debug side never acts on a locked part
		if (lk && c.from_dbg) begin
			cmd_allowed = 1'b0;
		end else if (lk && ser) begin
			// Serial boot lets only the unlocking erase through
			cmd_allowed = (c.kind == FSL_CMD_CHIP_ERASE);
		end else begin
			// User boot or unlocked part: everything passes
			cmd_allowed = 1'b1;
		end
	endfunction

	// True when a fetched halfword arms the lock
	function automatic logic code_arms(input logic [15:0] h);
		code_arms = (h == SEC_CODE_ARMED);
	endfunction

	// True on the edge that takes the security code answer
	function automatic logic fetch_taken(input fsl_state_t st, input logic ack);
		fetch_taken = (st == FSL_ST_FETCH) && ack;
	endfunction

	// True when read data must be replaced by the refusal pattern
	function automatic logic read_refused(input fsl_state_t st, input logic lk,
		input logic ser);
		read_refused = (st != FSL_ST_RUN) || (lk && ser);
	endfunction

	// Mode pin synchroniser; level counts once stages two and three agree
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			// All stages empty during reset
			mode_s1_reg <= 2'h0;
			mode_s2_reg <= 2'h0;
			mode_s3_reg <= 2'h0;
			mode_reg    <= 2'h0;
		end else begin
			// Shift the raw pin level through three stages
			mode_s1_reg <= boot_mode_pins_i;
			mode_s2_reg <= mode_s1_reg;
			mode_s3_reg <= mode_s2_reg;
			// A level that changed in flight is ignored until it settles
			if (mode_s2_reg == mode_s3_reg) begin
				mode_reg <= mode_s3_reg;
			end
		end
	end

	// Synchroniser for the rx select pin and the clock-present level
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			// All stages empty during reset
			misc_s1_reg <= 2'h0;
			misc_s2_reg <= 2'h0;
			misc_s3_reg <= 2'h0;
			misc_reg    <= 2'h0;
		end else begin
			// Shift both raw levels through three stages
			misc_s1_reg <= {serial_rx_select_pin_i, main_clk_present_i};
			misc_s2_reg <= misc_s1_reg;
			misc_s3_reg <= misc_s2_reg;
			// A level that changed in flight is ignored until it settles
			if (misc_s2_reg == misc_s3_reg) begin
				misc_reg <= misc_s3_reg;
			end
		end
	end

	// Boot state transitions
	always_comb begin
		// Hold the state unless a branch moves it
		state_next = state_reg;
		unique case (state_reg)
			// Let the pin synchronisers fill before the fetch
			FSL_ST_SETTLE: begin
				if (settle_reg == SETTLE_LAST) begin
					state_next = FSL_ST_FETCH;
				end
			end
			// Wait for the flash to answer the code read
			FSL_ST_FETCH: begin
				if (fetch_ack_i) begin
					state_next = FSL_ST_RUN;
				end
			end
			// Normal operation with the lock state known
			FSL_ST_RUN: begin
				state_next = FSL_ST_RUN; // Left only by reset
			end
			// Unused code falls back to the start
			default: begin
				state_next = FSL_ST_SETTLE;
			end
		endcase
	end

	// Boot state register and settle counter
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			// Every reset restarts the boot sequence
			state_reg  <= FSL_ST_SETTLE;
			settle_reg <= 3'h0;
		end else begin
			state_reg <= state_next;
			// Count only while settling; the count is dead after that
			if (state_reg == FSL_ST_SETTLE) begin
				settle_reg <= settle_reg + 3'h1;
			end
		end
	end

	// Security code fetch request, held until acknowledged
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			// No request and a zero address while reset stands
			fetch_req_o  <= 1'b0;
			fetch_addr_o <= 32'h0;
		end else begin
			// Request stands from settle end until the answer edge
			fetch_req_o  <= (state_next == FSL_ST_FETCH);
			fetch_addr_o <= SEC_CODE_ADDR;
		end
	end

	// Lock flag: loaded once per reset, erases never touch it
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			locked_reg <= 1'b0;
		end else if (fetch_taken(state_reg, fetch_ack_i)) begin
			// Sampled once per reset, so a code written later waits for the next one
			locked_reg <= code_arms(fetch_data_i);
		end
		// No other path clears the flag before reset
	end

	// Boot status latched with the code fetch
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			// Status empty until the code is read; the link starts at the slow rate
			status_o   <= '0;
			baud_bps_o <= BAUD_RC;
		end else if (fetch_taken(state_reg, fetch_ack_i)) begin
			// Same sample as the lock flag, so the two never differ
			status_o.locked        <= code_arms(fetch_data_i);
			// Pin levels were settled in the synchronisers by now
			status_o.serial_writer <= (mode_reg == MODE_SERIAL);
			status_o.async_link    <= misc_reg[1];
			status_o.use_rc        <= ~misc_reg[0] || (osc_sel_i == FSL_OSC_RC);
			// Without a main clock the link runs from the internal oscillator
			if (~misc_reg[0]) begin
				baud_bps_o <= BAUD_RC;
			end else begin
				baud_bps_o <= baud_of(osc_sel_i);
			end
		end
	end

	// Command gate; nothing passes before the lock state is known
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			// No answer leaves during reset
			cmd_accept_o <= 1'b0;
			cmd_reject_o <= 1'b0;
		end else begin
			// Pulses drop back unless set below
			cmd_accept_o <= 1'b0;
			cmd_reject_o <= 1'b0;
			// Answer every strobe exactly once, one cycle later
			if (cmd_i.valid) begin
				// Refuse until the lock state is known
				if (state_reg == FSL_ST_RUN &&
				    cmd_allowed(cmd_i, locked_reg, status_o.serial_writer)) begin
					cmd_accept_o <= 1'b1;
				end else begin
					// Refusal shows only here, never as an erase
					cmd_reject_o <= 1'b1;
				end
			end
		end
	end

	// Erase strobes; code and trimming areas always go together
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			erase_o <= '0;
		end else begin
			// Strobes last a single cycle
			erase_o <= '0;
			// Only an accepted command may strobe the array
			if (cmd_i.valid && state_reg == FSL_ST_RUN &&
			    cmd_allowed(cmd_i, locked_reg, status_o.serial_writer)) begin
				// Chip erase blanks the array, code and trimming data together
				if (cmd_i.kind == FSL_CMD_CHIP_ERASE) begin
					erase_o.chip <= 1'b1;
					erase_o.code <= 1'b1;
					erase_o.trim <= 1'b1;
				end else if (cmd_i.kind == FSL_CMD_CODE_ERASE ||
				             cmd_i.kind == FSL_CMD_TRIM_ERASE) begin
					// Either small erase takes its partner area too
					erase_o.code <= 1'b1;
					erase_o.trim <= 1'b1;
				end
			end
		end
	end

	// Read data gate
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rd_valid_o <= 1'b0;
			rd_data_o  <= 32'h0;
		end else begin
			// Valid follows the array one cycle later in every mode
			rd_valid_o <= rd_valid_i;
			// Refused reads still complete, carrying the blank pattern
			if (read_refused(state_reg, locked_reg, status_o.serial_writer)) begin
				rd_data_o <= READ_INVALID;
			end else begin
				// Open path: the array word passes untouched
				rd_data_o <= rd_data_i;
			end
		end
	end

	// Debug port enable, closed while locked or before the lock is known
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			dbg_enable_o <= 1'b0;
		end else begin
			// On the answer edge the fetched code decides, later the held flag
			// Nothing in this block can reopen the port while locked
			dbg_enable_o <= (state_next == FSL_ST_RUN) && !(state_reg == FSL_ST_FETCH
				? code_arms(fetch_data_i) : locked_reg);
		end
	end

endmodule

/* src/fsl_pkg.sv */
// Package for the flash security lock: constants, enumerations and carrier structs
package fsl_pkg;

	localparam logic [31:0] SEC_CODE_ADDR   = 32'h0010_0000; // Security code halfword address
	localparam logic [15:0] SEC_CODE_ARMED  = 16'h0001;      // Code value that arms the lock
	localparam logic [31:0] READ_INVALID    = 32'hffff_ffff; // Pattern returned for refused reads
	localparam logic [1:0]  MODE_USER       = 2'h0;          // Mode pins for user boot
	localparam logic [1:0]  MODE_SERIAL     = 2'h1;          // Mode pins for serial-writer boot
	localparam int          PIN_LOW_BIT     = 0;             // Position of the low mode pin
	localparam int          PIN_HIGH_BIT    = 1;             // Position of the high mode pin
	localparam int          SETTLE_CYCLES   = 4;             // Cycles for pin synchronisers to settle
	localparam logic [2:0]  SETTLE_LAST     = 3'(SETTLE_CYCLES - 1); // Final settle count
	localparam logic [15:0] BAUD_4M         = 16'd9600;      // Rate with 4 MHz source
	localparam logic [15:0] BAUD_8M         = 16'd19200;     // Rate with 8 MHz source
	localparam logic [15:0] BAUD_16M        = 16'd38400;     // Rate with 16 MHz source
	localparam logic [15:0] BAUD_20M        = 16'd48000;     // Rate with 20 MHz source
	localparam logic [15:0] BAUD_RC         = 16'd9600;      // Rate when running from internal RC

	// Flash command kinds seen by the gate
	typedef enum logic [2:0] {
		FSL_CMD_READ       = 3'h0,
		FSL_CMD_CHIP_ERASE = 3'h1,
		FSL_CMD_CODE_ERASE = 3'h2,
		FSL_CMD_TRIM_ERASE = 3'h3,
		FSL_CMD_OTHER      = 3'h4
	} fsl_cmd_kind_t;

	// Source oscillator choice
	typedef enum logic [2:0] {
		FSL_OSC_4M  = 3'h0,
		FSL_OSC_8M  = 3'h1,
		FSL_OSC_16M = 3'h2,
		FSL_OSC_20M = 3'h3,
		FSL_OSC_RC  = 3'h4
	} fsl_osc_t;

	// Boot sequence states
	typedef enum logic [1:0] {
		FSL_ST_SETTLE = 2'h0,
		FSL_ST_FETCH  = 2'h1,
		FSL_ST_RUN    = 2'h2
	} fsl_state_t;

	// Command request from the programmer or debug side
	typedef struct packed {
		logic          valid;    // One-cycle request strobe
		fsl_cmd_kind_t kind;     // Command kind
		logic          from_dbg; // Issued through the debug test port
	} fsl_cmd_t;

	// Erase strobes towards the flash array
	typedef struct packed {
		logic chip; // Whole-array erase
		logic code; // Security code area erase
		logic trim; // Oscillator trimming area erase
	} fsl_erase_t;

	// Latched boot status
	typedef struct packed {
		logic locked;        // Lock armed for this reset period
		logic serial_writer; // Booted into serial-writer mode
		logic async_link;    // Asynchronous link selected
		logic use_rc;        // Running from internal RC oscillator
	} fsl_status_t;

endpackage

/* testbench/fsl_flash_model.sv */
// Flash array model: answers the code fetch and takes erase strobes
module fsl_flash_model (
	input  wire logic                clock_i,
	input  wire logic                rst_i,
	input  wire logic                slow_i,       // Answer after extra waits
	input  wire logic                fetch_req_i,
	output logic                     fetch_ack_o,
	output logic [15:0]              fetch_data_o,
	input  wire fsl_pkg::fsl_erase_t erase_i,
	input  wire logic                code_wr_i,    // Programmer writes the code
	input  wire logic [15:0]         code_val_i
);
	timeunit 1ns;
	timeprecision 1ns;
	import fsl_pkg::*;
	logic [15:0] code_reg = 16'hffff; // Stored code, kept over reset like flash
	logic [2:0]  wait_reg;            // Waits spent on the pending fetch
	// Any erase strobe blanks the code area; a write programs it
	always_ff @(posedge clock_i) begin
		if (|erase_i) begin
			code_reg <= 16'hffff;
		end else if (code_wr_i) begin
			code_reg <= code_val_i;
		end
	end
	// One-cycle ack after the waits; data line toggles while not driven
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			wait_reg <= 3'h0;
			fetch_ack_o <= 1'b0;
			fetch_data_o <= 16'h5a5a;
		end else if (fetch_req_i && !fetch_ack_o && wait_reg == (slow_i ? 3'h5 : 3'h0)) begin
			fetch_ack_o <= 1'b1;
			fetch_data_o <= code_reg;
		end else begin
			wait_reg <= (fetch_req_i && !fetch_ack_o) ? wait_reg + 3'h1 : 3'h0;
			fetch_ack_o <= 1'b0;
			fetch_data_o <= ~fetch_data_o;
		end
	end
endmodule

/* testbench/fsl_lock_chk.sv */
// Port assertions for the flash security lock
module fsl_lock_chk (
	input wire logic                 clock_i,
	input wire logic                 rst_i,
	input wire logic                 fetch_req_o,
	input wire logic [31:0]          fetch_addr_o,
	input wire fsl_pkg::fsl_cmd_t    cmd_i,
	input wire logic                 cmd_accept_o,
	input wire logic                 cmd_reject_o,
	input wire fsl_pkg::fsl_erase_t  erase_o,
	input wire logic                 rd_valid_i,
	input wire logic [31:0]          rd_data_i,
	input wire logic [31:0]          rd_data_o,
	input wire logic                 dbg_enable_o,
	input wire fsl_pkg::fsl_status_t status_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import fsl_pkg::*;
	// All checks share the one clock and reset
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	a_fetch_addr: assert property (fetch_req_o |-> fetch_addr_o == SEC_CODE_ADDR)
		else $error("code fetch address wrong");
	a_one_answer: assert property (cmd_i.valid |=> cmd_accept_o != cmd_reject_o)
		else $error("command not answered once");
	a_no_stray: assert property (!$past(cmd_i.valid) |-> !cmd_accept_o && !cmd_reject_o)
		else $error("answer without command");
	a_serial_refuse: assert property (status_o.locked && status_o.serial_writer && cmd_i.valid
		&& cmd_i.kind != FSL_CMD_CHIP_ERASE |=> cmd_reject_o && !(|erase_o))
		else $error("locked serial mode took a command");
	a_serial_read: assert property (status_o.locked && status_o.serial_writer && rd_valid_i
		|=> rd_data_o == READ_INVALID)
		else $error("locked serial read leaked data");
	a_user_read: assert property ($past(status_o.locked) && !status_o.serial_writer && rd_valid_i
		|=> rd_data_o == $past(rd_data_i))
		else $error("locked user read not passed");
	a_dbg_blocked: assert property (status_o.locked |-> !dbg_enable_o)
		else $error("debug open while locked");
	a_dbg_no_unlock: assert property (status_o.locked && cmd_i.valid && cmd_i.from_dbg
		|=> cmd_reject_o && !(|erase_o))
		else $error("debug command acted while locked");
	a_erase_pair: assert property ((|erase_o) |-> erase_o.code && erase_o.trim && $past(cmd_i.valid))
		else $error("code and trim erase split");
	a_lock_held: assert property (!fetch_req_o && !$past(fetch_req_o) |-> $stable(status_o.locked))
		else $error("lock flag changed after boot");
endmodule
bind fsl_lock fsl_lock_chk chk_u (.clock_i(clock_i), .rst_i(rst_i), .fetch_req_o(fetch_req_o),
	.fetch_addr_o(fetch_addr_o), .cmd_i(cmd_i), .cmd_accept_o(cmd_accept_o),
	.cmd_reject_o(cmd_reject_o), .erase_o(erase_o), .rd_valid_i(rd_valid_i),
	.rd_data_i(rd_data_i), .rd_data_o(rd_data_o), .dbg_enable_o(dbg_enable_o), .status_o(status_o));

/* testbench/test_flash_security_lock.sv */
// Self-checking bench for the flash security lock
module test_flash_security_lock;
	timeunit 1ns;
	timeprecision 1ns;
	import fsl_pkg::*;
	logic        clk = 1'b0;      // 20 MHz clock
	logic        rst = 1'b1;      // Reset, high at start
	logic [1:0]  pins = MODE_USER; // Boot mode pins
	logic        rx_sel = 1'b1;   // Serial input level
	logic        mclk = 1'b1;     // Main oscillator present
	fsl_osc_t    osc = FSL_OSC_4M; // Source frequency
	fsl_cmd_t    cmd = '0;        // Command request
	logic        rd_valid = 1'b0; // Flash read strobe
	logic [31:0] rd_data = '0;    // Flash read word
	logic        slow = 1'b0;     // Model answers late
	logic        code_wr = 1'b0;  // Code write strobe
	logic [15:0] code_val = '0;   // Code to write
	logic        f_req, f_ack, acc, rej, rdv, dbg;
	logic [15:0] f_data, baud;
	logic [31:0] f_addr, rdd;
	fsl_erase_t  erase;
	fsl_status_t st;
	int          error_cnt = 0;   // Mismatches
	int          n_tests = 0;     // Comparisons
	always #25 clk = ~clk;
	fsl_lock dut_u (.clock_i(clk), .rst_i(rst), .boot_mode_pins_i(pins),
		.serial_rx_select_pin_i(rx_sel), .main_clk_present_i(mclk), .osc_sel_i(osc),
		.fetch_req_o(f_req), .fetch_addr_o(f_addr), .fetch_ack_i(f_ack), .fetch_data_i(f_data),
		.cmd_i(cmd), .cmd_accept_o(acc), .cmd_reject_o(rej), .erase_o(erase), .rd_valid_i(rd_valid),
		.rd_data_i(rd_data), .rd_valid_o(rdv), .rd_data_o(rdd), .dbg_enable_o(dbg), .status_o(st),
		.baud_bps_o(baud));
	fsl_flash_model flash_u (.clock_i(clk), .rst_i(rst), .slow_i(slow), .fetch_req_i(f_req),
		.fetch_ack_o(f_ack), .fetch_data_o(f_data), .erase_i(erase), .code_wr_i(code_wr),
		.code_val_i(code_val));
	// Compare one value and count it
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Print counts and verdict, then stop
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Reset with pins set, then wait for the code fetch to finish
	task automatic boot(input logic [1:0] m, input fsl_osc_t o, input logic mc, input logic sl,
		input logic rx);
		int n;
		@(posedge clk);
		rst <= 1'b1;
		pins <= m;
		osc <= o;
		mclk <= mc;
		slow <= sl;
		rx_sel <= rx;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		for (n = 0; n < 40 && f_req !== 1'b1; n++) @(posedge clk);
		for (n = 0; n < 40 && f_req !== 1'b0; n++) @(posedge clk);
		repeat (2) @(posedge clk);
		#1;
		chk("fetch_done", 1'b0, f_req);
	endtask
	// Lock flag, boot mode flag and debug gate
	task automatic chk_st(input logic lk, input logic sw);
		chk("locked", lk, st.locked);
		chk("serial_writer", sw, st.serial_writer);
		chk("dbg_enable", !lk, dbg);
	endtask
	// One command; judge the answer a cycle later
	task automatic send(input fsl_cmd_kind_t k, input logic d, input logic a, input logic [2:0] e);
		@(posedge clk);
		cmd <= '{1'b1, k, d};
		@(posedge clk);
		cmd <= '{1'b0, k, d};
		#1;
		chk("accept", a, acc);
		chk("reject", !a, rej);
		chk("erase", e, erase);
	endtask
	// One flash read through the gate
	task automatic rdchk(input logic [31:0] d, input logic [31:0] e);
		@(posedge clk);
		rd_valid <= 1'b1;
		rd_data <= d;
		@(posedge clk);
		rd_valid <= 1'b0;
		rd_data <= ~d;
		#1;
		chk("rd_valid", 1'b1, rdv);
		chk("rd_data", e, rdd);
	endtask
	// Blank code: all open; a code written now waits for the next reset
	task automatic t_open;
		boot(MODE_USER, FSL_OSC_4M, 1'b1, 1'b0, 1'b1);
		chk_st(1'b0, 1'b0);
		chk("baud", 16'h2580, baud);
		send(FSL_CMD_OTHER, 1'b1, 1'b1, 3'h0);
		send(FSL_CMD_TRIM_ERASE, 1'b0, 1'b1, 3'h3);
		rdchk(32'h1234_5678, 32'h1234_5678);
		@(posedge clk);
		code_wr <= 1'b1;
		code_val <= SEC_CODE_ARMED;
		@(posedge clk);
		code_wr <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
		chk("locked", 1'b0, st.locked);
	endtask
	// Armed code in user mode: flash open, debug shut
	task automatic t_user_locked;
		boot(MODE_USER, FSL_OSC_16M, 1'b1, 1'b0, 1'b1);
		chk_st(1'b1, 1'b0);
		chk("baud", 16'h9600, baud);
		chk("use_rc", 1'b0, st.use_rc);
		send(FSL_CMD_OTHER, 1'b0, 1'b1, 3'h0);
		send(FSL_CMD_CHIP_ERASE, 1'b1, 1'b0, 3'h0);
		rdchk(32'hcafe_0001, 32'hcafe_0001);
	endtask
	// Armed code in serial mode: only chip erase, then reset unlocks
	task automatic t_serial;
		boot(MODE_SERIAL, FSL_OSC_20M, 1'b1, 1'b1, 1'b1);
		chk_st(1'b1, 1'b1);
		chk("async_link", 1'b1, st.async_link);
		chk("baud", 16'hbb80, baud);
		send(FSL_CMD_OTHER, 1'b0, 1'b0, 3'h0);
		send(FSL_CMD_CODE_ERASE, 1'b0, 1'b0, 3'h0);
		rdchk(32'h0f0f_0f0f, READ_INVALID);
		send(FSL_CMD_CHIP_ERASE, 1'b0, 1'b1, 3'h7);
		chk("locked", 1'b1, st.locked);
		boot(MODE_USER, FSL_OSC_8M, 1'b1, 1'b0, 1'b1);
		chk_st(1'b0, 1'b0);
		chk("baud", 16'h4b00, baud);
	endtask
	// No main clock, then RC selected: internal oscillator; synchronous link selected in the first boot
	task automatic t_rc;
		boot(MODE_SERIAL, FSL_OSC_16M, 1'b0, 1'b0, 1'b0);
		chk("use_rc", 1'b1, st.use_rc);
		chk("baud", 16'h2580, baud);
		chk("async_link", 1'b0, st.async_link);
		boot(MODE_USER, FSL_OSC_RC, 1'b1, 1'b0, 1'b1);
		chk("use_rc", 1'b1, st.use_rc);
		chk("baud", BAUD_RC, baud);
	endtask
	// Main sequence
	initial begin
		t_open();
		t_user_locked();
		t_serial();
		t_rc();
		complete_run();
	end
	// Watchdog against a hung fetch or handshake
	initial begin
		#200000;
		error_cnt++;
		complete_run();
	end
endmodule
